// ### sfx_pkg.sv
// Purpose: constants for the serial flash xip and power-up controller
// Assumes: 100 MHz CLK, host serial clock as a separate domain
// Notes: times are in their printed units, counts derived from CLK_MHZ
package sfx_pkg;
	localparam int CLK_MHZ = 100;
	// power-up times in microseconds
	localparam int FAST_BOOT_READ_US = 100;
	localparam int FAST_BOOT_WRITE_US = 500;
	localparam int FULL_ACCESS_US = 600;
	localparam int WRITE_INHIBIT_US = 10;
	localparam int SELECT_DELAY_US = 5;
	// longest times round down, least times round up
	localparam int FAST_BOOT_READ_CYC = FAST_BOOT_READ_US * CLK_MHZ;
	localparam int FAST_BOOT_WRITE_CYC = FAST_BOOT_WRITE_US * CLK_MHZ;
	localparam int FULL_ACCESS_CYC = FULL_ACCESS_US * CLK_MHZ;
	localparam int WRITE_INHIBIT_CYC = WRITE_INHIBIT_US * CLK_MHZ;
	localparam int SELECT_DELAY_CYC = SELECT_DELAY_US * CLK_MHZ;
	localparam int TMR_W = 20;
	// command codes
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_STATUS_POLL = 8'h05;
	localparam logic [7:0] CMD_FAST_READ_1 = 8'h0B;
	localparam logic [7:0] CMD_FAST_READ_2 = 8'hBB;
	localparam logic [7:0] CMD_FAST_READ_4 = 8'hEB;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_READ_VCR = 8'h85;
	localparam logic [7:0] CMD_WRITE_VCR = 8'h81;
	localparam logic [7:0] CMD_READ_EVCR = 8'h65;
	localparam logic [7:0] CMD_WRITE_EVCR = 8'h61;
	// configuration bit positions
	localparam int VCR_XIP_BIT = 3;
	localparam int NONVOLATILE_CONFIG_REG_FAST_POR_BIT = 5;
	localparam int NONVOLATILE_CONFIG_REG_XIP_LSB = 9;
	localparam int NONVOLATILE_CONFIG_REG_XIP_MSB = 11;
	// nonvolatile xip field codes
	localparam logic [2:0] NV_XIP_SINGLE = 3'h0;
	localparam logic [2:0] NV_XIP_DUAL = 3'h1;
	localparam logic [2:0] NV_XIP_QUAD = 3'h2;
	// link frame figures
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] ADDR_CLK_1 = 6'h18;
	localparam logic [5:0] ADDR_CLK_2 = 6'h0C;
	localparam logic [5:0] ADDR_CLK_4 = 6'h06;
	localparam logic [5:0] RESCUE_LEN_0 = 6'h07;
	localparam logic [5:0] RESCUE_LEN_1 = 6'h0D;
	localparam logic [5:0] RESCUE_LEN_2 = 6'h19;
	localparam logic [5:0] PROTO_FIX_LEN = 6'h08;
	localparam logic [5:0] CNT_MAX = 6'h3F;
	typedef enum logic [1:0] {SFX_L1, SFX_L2, SFX_L4} sfx_lanes_t;
	typedef enum {SFX_PWR_WAIT, SFX_PWR_FAST, SFX_PWR_PHASE2,
		SFX_PWR_FULL} sfx_pwr_t;
endpackage : sfx_pkg

// ### sfx_ctrl.sv
// Purpose: xip hold/exit tracking and power-up sequencing of a serial flash
// Assumes: SCK runs only while CS_N is low; state settles while deselected
// Notes:
// Notes on behaviour
// - clearing the volatile xip bit arms xip entry.
// - arming alone never enters xip; a fast read is needed.
// - confirmation bit on io0 at first dummy clock; zero keeps xip.
// - in xip, after reselection first three bytes are address, no opcode.
// - confirmation one leaves xip; next selection starts with an opcode.
// - io1 to io3 are ignored at the confirmation clock.
// - reset pin restores power-up protocol; in quad only while deselected.
// - basic variants enter xip directly with confirmation one.
// - io0 high selections of 7, 13, 25 clocks exit xip, nothing else.
// - enabled controller reset returns the memory to power-on state, except that a forced single-line protocol stays set.
// - write enable and modify commands ignored until write inhibit ends.
// - after power-up standby, latches clear, lock pairs zero.
// - reads accepted once select delay ends, before write inhibit ends.
// - fast boot allows reads and config writes within 100 us.
// - fast boot first write enable starts 500 us phase, polling only.
// - in that phase both flags read one; afterwards only latch stays.
// - fast boot is chosen by bit 5 of the nonvolatile config.
// - full access no later than 600 us after power-up.
// - after the 7, 13, 25 sequence, 8 clocks with io0 and io3 high force single-line protocol.
// - nonvolatile xip field takes effect only at next power-up or enabled pin reset.
// - under fast boot a write enable leaves the fast boot state.
`timescale 1ns/100ps
module sfx_ctrl #(
	parameter int READ_DELAY_CYC = sfx_pkg::FAST_BOOT_READ_CYC,
	parameter int PHASE2_CYC = sfx_pkg::FAST_BOOT_WRITE_CYC,
	parameter int FULL_CYC = sfx_pkg::FULL_ACCESS_CYC,
	parameter int INHIBIT_CYC = sfx_pkg::WRITE_INHIBIT_CYC,
	parameter int SELECT_CYC = sfx_pkg::SELECT_DELAY_CYC
) (
	// system
	input wire logic CLK,
	input wire logic RST,
	// serial link
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic IO0,
	input wire logic IO1,
	input wire logic IO2,
	input wire logic IO3,
	input wire logic RESET_N,
	// configuration
	input wire logic RESET_EN,
	input wire logic BASIC_XIP,
	input wire logic [15:0] VOLATILE_CONFIG_REG,
	input wire logic [15:0] NONVOLATILE_CONFIG_REG,
	// status
	output logic XIP_ACTIVE,
	output logic [1:0] XIP_LANES,
	output logic PROTO_FORCED,
	output logic READ_OK,
	output logic WRITE_OK,
	output logic WRITE_ENABLE_LATCH,
	output logic WRITE_IN_PROGRESS,
	output logic STANDBY,
	output logic LOCK_WRITE,
	output logic LOCK_DOWN,
	// decoded commands
	output logic CMD_STROBE,
	output logic [7:0] CMD_CODE,
	output logic CMD_ACCEPT
);
	import sfx_pkg::*;

	function automatic logic [5:0] addr_clocks(input logic [1:0] lanes);
		addr_clocks = (lanes == 2'(SFX_L4)) ? ADDR_CLK_4 :
			(lanes == 2'(SFX_L2)) ? ADDR_CLK_2 : ADDR_CLK_1;
	endfunction : addr_clocks

	function automatic logic [1:0] lanes_of(input logic [7:0] op);
		lanes_of = (op == CMD_FAST_READ_4) ? 2'(SFX_L4) :
			(op == CMD_FAST_READ_2) ? 2'(SFX_L2) : 2'(SFX_L1);
	endfunction : lanes_of

	function automatic logic fast_op(input logic [7:0] op);
		fast_op = (op == CMD_FAST_READ_1) || (op == CMD_FAST_READ_2) ||
			(op == CMD_FAST_READ_4);
	endfunction : fast_op

	// ---------------- link domain (SCK) ----------------
	// frame flag is cleared by deselection; counter restarts at first edge
	logic in_frame_reg;
	logic [5:0] cnt_reg;
	logic [7:0] op_reg;
	logic conf_reg;
	logic conf_seen_reg;
	logic io0_high_reg;
	logic io3_high_reg;
	logic [5:0] cnt_now;
	logic [7:0] op_now;
	logic [5:0] conf_idx;
	logic frame_fast;

	// xip and xip_lanes are updated by CLK logic once deselected, steady while selected except for a pin reset
	logic xip_reg;
	logic [1:0] lanes_reg;

	assign cnt_now = in_frame_reg ? cnt_reg : 6'h00;
	assign op_now = in_frame_reg ? op_reg : 8'h00;
	assign frame_fast = fast_op(op_now);
	// in xip no opcode precedes the address
	assign conf_idx = xip_reg ? addr_clocks(lanes_reg) :
		6'(CMD_BITS + addr_clocks(lanes_of(op_now)));

	always_ff @(posedge SCK or posedge CS_N) begin
		if (CS_N) begin
			in_frame_reg <= 1'b0;
		end else begin
			in_frame_reg <= 1'b1;
		end
	end

	always_ff @(posedge SCK) begin
		cnt_reg <= (cnt_now == CNT_MAX) ? CNT_MAX : 6'(cnt_now + 6'h01);
		if (cnt_now < CMD_BITS) begin
			op_reg <= {op_now[6:0], IO0};
		end
		io0_high_reg <= (in_frame_reg ? io0_high_reg : 1'b1) & IO0;
		io3_high_reg <= (in_frame_reg ? io3_high_reg : 1'b1) & IO3;
		if (!in_frame_reg) begin
			conf_seen_reg <= 1'b0;
		end else if (cnt_now == conf_idx && (xip_reg || frame_fast)) begin
			// rising edge, io0 only; io1..io3 don't care
			conf_seen_reg <= 1'b1;
			conf_reg <= IO0;
		end
	end

	// ---------------- pin synchronisers into CLK ----------------
	logic [2:0] cs_sync;
	logic [2:0] rn_sync;
	logic cs_state_reg;
	logic rn_state_reg;
	logic cs_rise;
	logic rn_fall;

	always_ff @(posedge CLK) begin
		cs_sync <= {cs_sync[1:0], CS_N};
		rn_sync <= {rn_sync[1:0], RESET_N};
		if (RST) begin
			cs_state_reg <= 1'b1;
			rn_state_reg <= 1'b1;
		end else begin
			if (cs_sync[1] == cs_sync[2]) begin
				cs_state_reg <= cs_sync[2];
			end
			if (rn_sync[1] == rn_sync[2]) begin
				rn_state_reg <= rn_sync[2];
			end
		end
	end

	assign cs_rise = !cs_state_reg && cs_sync[1] && cs_sync[2];
	assign rn_fall = rn_state_reg && !rn_sync[1] && !rn_sync[2] && RESET_EN;

	// ---------------- frame decode in CLK ----------------
	// link registers are still while deselected, so they are read here
	logic frame_ok;
	logic rescue_hit;
	logic proto_hit;
	logic [1:0] step_reg;
	logic pin_reset;
	logic enter_xip;
	logic leave_xip;
	logic [1:0] nv_lanes;
	logic nv_xip;
	logic load_reg;
	logic fast_por_reg;
	logic op_fast;

	assign frame_ok = cs_rise && cnt_reg != 6'h00;
	// frame flag is already cleared here, so decode the held opcode
	assign op_fast = fast_op(op_reg);
	assign rescue_hit = frame_ok && io0_high_reg &&
		((step_reg == 2'h0 && cnt_reg == RESCUE_LEN_0) ||
		(step_reg == 2'h1 && cnt_reg == RESCUE_LEN_1) ||
		(step_reg == 2'h2 && cnt_reg == RESCUE_LEN_2));
	assign proto_hit = frame_ok && step_reg == 2'h3 && io0_high_reg &&
		io3_high_reg && cnt_reg == PROTO_FIX_LEN;
	// quad xip honours the pin only while deselected
	assign pin_reset = rn_fall &&
		(!xip_reg || lanes_reg != 2'(SFX_L4) || cs_state_reg);
	// arming or a basic variant plus fast read
	assign enter_xip = frame_ok && !xip_reg && op_fast && conf_seen_reg &&
		((!VOLATILE_CONFIG_REG[VCR_XIP_BIT] && !conf_reg) ||
		(BASIC_XIP && conf_reg));
	// one on io0 at the confirmation clock leaves xip
	assign leave_xip = frame_ok && xip_reg && conf_seen_reg && conf_reg;
	assign nv_xip = NONVOLATILE_CONFIG_REG[NONVOLATILE_CONFIG_REG_XIP_MSB:NONVOLATILE_CONFIG_REG_XIP_LSB] ==
		NV_XIP_SINGLE || NONVOLATILE_CONFIG_REG[NONVOLATILE_CONFIG_REG_XIP_MSB:NONVOLATILE_CONFIG_REG_XIP_LSB] ==
		NV_XIP_DUAL || NONVOLATILE_CONFIG_REG[NONVOLATILE_CONFIG_REG_XIP_MSB:NONVOLATILE_CONFIG_REG_XIP_LSB] ==
		NV_XIP_QUAD;
	assign nv_lanes = NONVOLATILE_CONFIG_REG[NONVOLATILE_CONFIG_REG_XIP_MSB:NONVOLATILE_CONFIG_REG_XIP_LSB] ==
		NV_XIP_QUAD ? 2'(SFX_L4) :
		NONVOLATILE_CONFIG_REG[NONVOLATILE_CONFIG_REG_XIP_MSB:NONVOLATILE_CONFIG_REG_XIP_LSB] == NV_XIP_DUAL ?
		2'(SFX_L2) : 2'(SFX_L1);

	// straps are caught one cycle after reset release
	always_ff @(posedge CLK) begin
		if (RST) begin
			load_reg <= 1'b1;
			xip_reg <= 1'b0;
			lanes_reg <= 2'(SFX_L1);
			step_reg <= 2'h0;
			fast_por_reg <= 1'b0;
			PROTO_FORCED <= 1'b0;
		end else begin
			load_reg <= pin_reset;
			if (load_reg) begin
				fast_por_reg <= !NONVOLATILE_CONFIG_REG[NONVOLATILE_CONFIG_REG_FAST_POR_BIT];
				xip_reg <= nv_xip && !PROTO_FORCED;
				lanes_reg <= nv_lanes;
			end else if (rescue_hit && step_reg == 2'h2) begin
				xip_reg <= 1'b0; // exit only, nothing else reset
			end else if (enter_xip) begin
				xip_reg <= 1'b1;
				lanes_reg <= lanes_of(op_reg);
			end else if (leave_xip) begin
				xip_reg <= 1'b0;
			end
			// wrong length or level restarts the sequence
			if (rescue_hit) begin
				step_reg <= 2'(step_reg + 2'h1);
			end else if (frame_ok) begin
				step_reg <= 2'h0;
			end
			if (proto_hit) begin
				PROTO_FORCED <= 1'b1; // held until next power-up
				lanes_reg <= 2'(SFX_L1);
			end
		end
	end

	assign XIP_ACTIVE = xip_reg;
	assign XIP_LANES = lanes_reg;

	// ---------------- power-up sequencing ----------------
	sfx_pwr_t pwr_reg;
	sfx_pwr_t pwr_next;
	logic [TMR_W-1:0] tmr_reg;
	logic [TMR_W-1:0] ph2_reg;
	logic is_cmd;
	logic is_write_enable_cmd;
	logic is_read;
	logic is_cfg;
	logic accept_now;
	logic inhibit_done;
	logic full_done;
	logic read_now;

	assign is_cmd = frame_ok && !xip_reg && cnt_reg >= CMD_BITS;
	assign is_write_enable_cmd = op_reg == CMD_WRITE_ENABLE;
	assign is_read = op_reg == CMD_READ || op_fast ||
		op_reg == CMD_STATUS_POLL || op_reg == CMD_READ_VCR ||
		op_reg == CMD_READ_EVCR;
	assign is_cfg = op_reg == CMD_WRITE_VCR || op_reg == CMD_WRITE_EVCR;
	assign inhibit_done = tmr_reg >= TMR_W'(INHIBIT_CYC);
	// cap at the full access figure
	assign full_done = tmr_reg >= TMR_W'(FULL_CYC);
	// reads open at select delay, or at fast boot read time
	assign read_now = fast_por_reg ? tmr_reg >= TMR_W'(READ_DELAY_CYC) :
		tmr_reg >= TMR_W'(SELECT_CYC);

	always_comb begin
		pwr_next = pwr_reg;
		accept_now = 1'b0;
		case (pwr_reg)
			SFX_PWR_WAIT: begin
				// write enable and modifies refused until inhibit ends
				accept_now = is_read && read_now;
				if (full_done || (inhibit_done && !fast_por_reg)) begin
					pwr_next = SFX_PWR_FULL;
				end else if (fast_por_reg && read_now) begin
					pwr_next = SFX_PWR_FAST;
				end
			end
			SFX_PWR_FAST: begin
				// config writes need no latch here
				accept_now = is_read || is_cfg || is_write_enable_cmd;
				if (full_done) begin
					pwr_next = SFX_PWR_FULL;
				end else if (is_cmd && is_write_enable_cmd) begin
					pwr_next = SFX_PWR_PHASE2;
				end
			end
			SFX_PWR_PHASE2: begin
				accept_now = op_reg == CMD_STATUS_POLL;
				// full access cap also cuts phase two short
				if (full_done || ph2_reg >= TMR_W'(PHASE2_CYC)) begin
					pwr_next = SFX_PWR_FULL;
				end
			end
			SFX_PWR_FULL: begin
				accept_now = 1'b1;
			end
			default: begin
				pwr_next = SFX_PWR_WAIT;
			end
		endcase
	end

	// RST is the power-on reset; pin_reset is the enabled controller reset
	always_ff @(posedge CLK) begin
		if (RST || pin_reset) begin
			pwr_reg <= SFX_PWR_WAIT;
			tmr_reg <= '0;
			ph2_reg <= '0;
			WRITE_ENABLE_LATCH <= 1'b0;
			WRITE_IN_PROGRESS <= 1'b0;
			READ_OK <= 1'b0;
			WRITE_OK <= 1'b0;
			STANDBY <= 1'b1;
			LOCK_WRITE <= 1'b0;
			LOCK_DOWN <= 1'b0;
			CMD_STROBE <= 1'b0;
			CMD_CODE <= 8'h00;
			CMD_ACCEPT <= 1'b0;
		end else begin
			pwr_reg <= pwr_next;
			if (!full_done) begin
				tmr_reg <= TMR_W'(tmr_reg + 1'b1);
			end
			if (pwr_reg == SFX_PWR_PHASE2) begin
				ph2_reg <= TMR_W'(ph2_reg + 1'b1);
			end
			READ_OK <= pwr_next != SFX_PWR_WAIT || read_now;
			WRITE_OK <= pwr_next == SFX_PWR_FULL;
			// both flags set in phase two, latch kept after
			if (pwr_next == SFX_PWR_PHASE2) begin
				WRITE_ENABLE_LATCH <= 1'b1;
				WRITE_IN_PROGRESS <= 1'b1;
			end else if (pwr_reg == SFX_PWR_PHASE2) begin
				WRITE_IN_PROGRESS <= 1'b0;
			end else if (is_cmd && is_write_enable_cmd && pwr_reg == SFX_PWR_FULL) begin
				WRITE_ENABLE_LATCH <= 1'b1;
			end
			CMD_STROBE <= is_cmd;
			if (is_cmd) begin
				CMD_CODE <= op_reg;
			end
			CMD_ACCEPT <= is_cmd && accept_now;
		end
	end

	// ---------------- checks ----------------
	a_write_enable_cmd_inhibit: assert property (@(posedge CLK) disable iff (RST)
		(is_cmd && is_write_enable_cmd && pwr_reg == SFX_PWR_WAIT) |=> !CMD_ACCEPT)
		else $error("write enable accepted during inhibit");
	a_phase2_flags: assert property (@(posedge CLK) disable iff (RST)
		(pwr_reg == SFX_PWR_PHASE2 && pwr_next == SFX_PWR_PHASE2 &&
		!pin_reset) |=>
		(WRITE_ENABLE_LATCH && WRITE_IN_PROGRESS))
		else $error("phase two flags not both set");
	a_phase2_end: assert property (@(posedge CLK) disable iff (RST)
		(pwr_reg == SFX_PWR_PHASE2 && pwr_next == SFX_PWR_FULL && !pin_reset)
		|=> (!WRITE_IN_PROGRESS && WRITE_ENABLE_LATCH))
		else $error("phase two end flags wrong");
	a_phase2_poll: assert property (@(posedge CLK) disable iff (RST)
		(pwr_reg == SFX_PWR_PHASE2 && is_cmd && op_reg != CMD_STATUS_POLL
		&& !pin_reset) |=> !CMD_ACCEPT)
		else $error("non-poll command accepted in phase two");
	a_full_access: assert property (@(posedge CLK) disable iff (RST)
		(full_done && !pin_reset) |=> WRITE_OK)
		else $error("not fully accessible at full access time");
	a_power_state: assert property (@(posedge CLK)
		$fell(RST) |-> (!WRITE_ENABLE_LATCH && !WRITE_IN_PROGRESS && STANDBY
		&& !LOCK_WRITE && !LOCK_DOWN))
		else $error("power-up state wrong");
	a_xip_exit: assert property (@(posedge CLK) disable iff (RST)
		(leave_xip && !load_reg && !enter_xip) |=> !XIP_ACTIVE)
		else $error("confirmation one did not leave xip");
	a_xip_hold: assert property (@(posedge CLK) disable iff (RST)
		(frame_ok && xip_reg && conf_seen_reg && !conf_reg && !load_reg &&
		!rescue_hit) |=> XIP_ACTIVE)
		else $error("confirmation zero did not hold xip");
	a_rescue_exit: assert property (@(posedge CLK) disable iff (RST)
		(rescue_hit && step_reg == 2'h2 && !load_reg) |=>
		(!XIP_ACTIVE && step_reg == 2'h3))
		else $error("rescue sequence did not exit xip");
	a_arm_only: assert property (@(posedge CLK) disable iff (RST)
		(!xip_reg && !enter_xip && !load_reg) |=> !XIP_ACTIVE)
		else $error("xip entered without a fast read");
endmodule : sfx_ctrl

// ### sfx_host_model.sv
// Purpose: behavioural host controller on the serial link
// Assumes: one frame per toggle of req, answered by toggling ack
// Notes: serial clock stands still low between frames
`timescale 1ns/100ps
module sfx_host_model (
	// bench side
	input wire logic req,
	input wire logic [5:0] n_clk,
	input wire logic [63:0] bits,
	input wire logic io3_hi,
	output logic ack,
	// serial link
	output logic sck,
	output logic cs_n,
	output logic io0,
	output logic io1,
	output logic io2,
	output logic io3
);
	int i;
	initial begin
		{ack, sck, io0, io1, io2, io3} = '0;
		cs_n = 1'b1;
		forever begin
			// start only on a real toggle, not on power-up settling
			wait (req === !ack);
			#(3.3 + bits[40:38]);
			cs_n = 1'b0;
			for (i = 0; i < n_clk; i++) begin
				// spare lanes toggle as do-not-care, except io3, which is held high while io3_hi is set
				io0 = bits[i];
				io1 = ~io1;
				io2 = io1 ^ bits[i];
				io3 = io3_hi | io2;
				#40 sck = 1'b1;
				#80 sck = 1'b0;
				#40;
			end
			cs_n = 1'b1;
			// released lines show the inverse of their last level
			{io0, io1, io2, io3} = ~{io0, io1, io2, io3};
			// deselect time well above 50 ns
			#200 ack = req;
		end
	end
endmodule : sfx_host_model

// ### sfx_ctrl_tb_top.sv
// Purpose: self-checking bench for the xip and power-up controller
// Assumes: short power counts by parameter, host model on the link
// Notes: link clock 160 ns, started at varying offsets from CLK
`timescale 1ns/100ps
module sfx_ctrl_tb_top;
	import sfx_pkg::*;
	localparam int RD = 300;
	localparam int P2 = 800;
	localparam int FULL = 2000;
	localparam int INH = 600;
	localparam int SEL = 200;
	logic clk, rst, reset_n, reset_en, basic_xip;
	logic sck, cs_n, io0, io1, io2, io3;
	logic [15:0] volatile_config_reg, nonvolatile_config_reg;
	logic xip_active, proto_forced, read_ok, write_ok, write_enable_latch, write_in_progress;
	logic standby, lock_write, lock_down, cmd_strobe, cmd_accept;
	logic [1:0] xip_lanes;
	logic [7:0] cmd_code, code_v;
	logic acc_v, f_req, f_ack, f_io3;
	logic [5:0] f_n;
	logic [63:0] f_bits;
	logic [31:0] seed = 32'h0000001F;
	int bad_count = 0;
	int n_compared = 0;
	int stb_n, m;
	logic [7:0] ops [3] = '{CMD_FAST_READ_1, CMD_FAST_READ_2, CMD_FAST_READ_4};
	int na [3] = '{24, 12, 6};

	sfx_ctrl #(.READ_DELAY_CYC(RD), .PHASE2_CYC(P2), .FULL_CYC(FULL),
		.INHIBIT_CYC(INH), .SELECT_CYC(SEL)) sfx_ctrl_i (
		.CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .IO0(io0),
		.IO1(io1), .IO2(io2), .IO3(io3), .RESET_N(reset_n),
		.RESET_EN(reset_en), .BASIC_XIP(basic_xip),
		.VOLATILE_CONFIG_REG(volatile_config_reg), .NONVOLATILE_CONFIG_REG(nonvolatile_config_reg),
		.XIP_ACTIVE(xip_active), .XIP_LANES(xip_lanes),
		.PROTO_FORCED(proto_forced), .READ_OK(read_ok),
		.WRITE_OK(write_ok), .WRITE_ENABLE_LATCH(write_enable_latch),
		.WRITE_IN_PROGRESS(write_in_progress), .STANDBY(standby),
		.LOCK_WRITE(lock_write), .LOCK_DOWN(lock_down),
		.CMD_STROBE(cmd_strobe), .CMD_CODE(cmd_code),
		.CMD_ACCEPT(cmd_accept));

	sfx_host_model sfx_host_model_i (.req(f_req), .n_clk(f_n),
		.bits(f_bits), .io3_hi(f_io3), .ack(f_ack), .sck(sck),
		.cs_n(cs_n), .io0(io0), .io1(io1), .io2(io2), .io3(io3));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (cmd_strobe === 1'b1) begin
			stb_n <= stb_n + 1;
			acc_v <= cmd_accept;
			code_v <= cmd_code;
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic frame(input int n, input logic [63:0] b, input logic h3);
		int k;
		@(negedge clk);
		{f_n, f_bits, f_io3} = {n[5:0], b, h3};
		stb_n = 0;
		f_req = ~f_req;
		for (k = 0; k < 5000 && f_ack !== f_req; k++) @(negedge clk);
		if (f_ack !== f_req) begin
			bad_count++;
			$display("MISMATCH frame_ack expected %h seen %h", f_req, f_ack);
		end
	endtask : frame

	task automatic cmd(input logic [7:0] op);
		logic [7:0] r;
		r = {<<{op}};
		frame(8, {56'h0, r}, 1'b0);
	endtask : cmd

	task automatic fread(input logic [7:0] op, input int nc, input logic xip,
		input logic cf);
		logic [63:0] b;
		int p;
		b = {xs(), xs()};
		p = xip ? 0 : 8;
		if (!xip) b[7:0] = {<<{op}};
		b[p + nc] = cf;
		// confirmation plus two further dummy clocks
		frame(p + nc + 3, b, 1'b0);
	endtask : fread

	task automatic rescue(input int last, input logic h3);
		frame(7, '1, 1'b0);
		frame(13, '1, 1'b0);
		frame(25, '1, 1'b0);
		if (last > 0) frame(last, '1, h3);
	endtask : rescue

	task automatic pin_pulse();
		@(negedge clk);
		reset_n = 1'b0;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (10) @(negedge clk);
	endtask : pin_pulse

	task automatic por(input logic [15:0] nv);
		@(negedge clk);
		nonvolatile_config_reg = nv; // config written again before power-up
		rst = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
	endtask : por

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict

	initial begin
		#400000;
		bad_count++;
		$display("watchdog expired");
		give_verdict();
	end

	initial begin
		{clk, reset_en, basic_xip, f_req, f_io3} = '0;
		{rst, reset_n} = 2'b11;
		{f_n, f_bits} = '0;
		volatile_config_reg = 16'hFFFF;
		nonvolatile_config_reg = 16'h0E20;
		stb_n = 0;
		por(16'h0E20);
		repeat (3) @(negedge clk);
		chk("standby", standby, 1'b1);
		chk("flags", {write_enable_latch, write_in_progress, lock_write, lock_down}, 4'h0);
		repeat (SEL - 8) @(negedge clk);
		chk("read early", read_ok, 1'b0);
		repeat (10) @(negedge clk);
		chk("read ok", {read_ok, write_ok}, 2'b10);
		cmd(CMD_WRITE_ENABLE);
		chk("write_enable_cmd early", {acc_v, write_enable_latch}, 2'b00);
		cmd(CMD_READ);
		chk("read taken", acc_v, 1'b1);
		repeat (150) @(negedge clk);
		cmd(CMD_WRITE_ENABLE);
		chk("write_enable_cmd late", {write_ok, write_enable_latch}, 2'b11);
		$display("test done: power without fast boot");
		por(16'h0E00);
		repeat (RD - 5) @(negedge clk);
		chk("fast read early", read_ok, 1'b0);
		repeat (10) @(negedge clk);
		chk("fast read ok", read_ok, 1'b1);
		cmd(CMD_WRITE_VCR);
		chk("vcr write", acc_v, 1'b1);
		cmd(CMD_WRITE_ENABLE);
		chk("phase two", {write_enable_latch, write_in_progress, write_ok}, 3'b110);
		cmd(CMD_READ);
		chk("read in phase", acc_v, 1'b0);
		cmd(CMD_STATUS_POLL);
		chk("poll in phase", acc_v, 1'b1);
		repeat (P2 - 250) @(negedge clk);
		chk("phase end", {write_enable_latch, write_in_progress, write_ok}, 3'b101);
		por(16'h0E00);
		repeat (FULL + 5) @(negedge clk);
		chk("full access", write_ok, 1'b1);
		$display("test done: fast boot");
		por(16'h0E20);
		repeat (INH + 10) @(negedge clk);
		for (m = 0; m < 3; m++) begin
			volatile_config_reg = 16'hFFFF;
			fread(ops[m], na[m], 1'b0, 1'b0);
			chk("unarmed", xip_active, 1'b0);
			volatile_config_reg = 16'hFFF7;
			repeat (20) @(negedge clk);
			chk("armed only", xip_active, 1'b0);
			fread(ops[m], na[m], 1'b0, 1'b0);
			chk("entered", xip_active, 1'b1);
			chk("lanes", xip_lanes, 16'(m));
			fread(8'h00, na[m], 1'b1, 1'b0);
			chk("held", xip_active, 1'b1);
			chk("no opcode", 16'(stb_n), 16'h0);
			fread(8'h00, na[m], 1'b1, 1'b1);
			chk("left", xip_active, 1'b0);
			cmd(CMD_STATUS_POLL);
			chk("opcode again", code_v, CMD_STATUS_POLL);
		end
		$display("test done: xip hold and exit");
		basic_xip = 1'b1;
		volatile_config_reg = 16'hFFFF;
		fread(CMD_FAST_READ_1, 24, 1'b0, 1'b1);
		chk("basic entry", xip_active, 1'b1);
		rescue(0, 1'b0);
		chk("rescue exit", xip_active, 1'b0);
		chk("no reset", {proto_forced, write_ok}, 2'b01);
		frame(9, '1, 1'b1);
		chk("long fix", proto_forced, 1'b0);
		rescue(8, 1'b1);
		chk("fixed", {proto_forced, xip_lanes}, 3'b100);
		$display("test done: rescue");
		basic_xip = 1'b0;
		por(16'h0020);
		repeat (INH + 10) @(negedge clk);
		chk("nv single", {xip_active, xip_lanes}, 3'b100);
		nonvolatile_config_reg = 16'h0420;
		repeat (5) @(negedge clk);
		chk("nv waits", xip_lanes, 2'b00);
		nonvolatile_config_reg = 16'h0020;
		fread(8'h00, 24, 1'b1, 1'b1);
		pin_pulse();
		chk("pin off", {xip_active, write_ok}, 2'b01);
		reset_en = 1'b1;
		pin_pulse();
		chk("pin on", {xip_active, write_ok}, 2'b10);
		por(16'h0420);
		repeat (INH + 10) @(negedge clk);
		chk("nv quad", {xip_active, xip_lanes}, 3'b110);
		fork
			frame(5, '1, 1'b0);
			begin
				repeat (30) @(negedge clk);
				pin_pulse();
			end
		join
		chk("pin selected", write_ok, 1'b1);
		pin_pulse();
		chk("pin deselected", write_ok, 1'b0);
		$display("test done: reset pin");
		give_verdict();
	end
endmodule : sfx_ctrl_tb_top
